// *** sdmc_cal_master.sv ***
// calibration master model: mode commands as one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module sdmc_cal_master (
   input wire logic hclk,
   output logic enter_command_request,
   output logic enter_raw_request,
   output logic enter_normal_request
);
   initial begin
      enter_command_request = 1'b0;
      enter_raw_request = 1'b0;
      enter_normal_request = 1'b0;
   end
   // kind 0 command, 1 raw, 2 normal; callers send the command early in the window
   task automatic send(input int kind);
      @(posedge hclk);
      enter_command_request <= kind == 0;
      enter_raw_request <= kind == 1;
      enter_normal_request <= kind == 2;
      @(posedge hclk);
      enter_command_request <= 1'b0;
      enter_raw_request <= 1'b0;
      enter_normal_request <= 1'b0;
   endtask
endmodule // sdmc_cal_master
`default_nettype wire

// *** sdmc_core.sv ***
// diagnostics, nonvolatile signature and operating mode control with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
module sdmc_core #(
   parameter int unsigned TEMP_DLY = sdmc_pkg::TEMP_DLY_TICKS,
   parameter int unsigned RECOVER = sdmc_pkg::RECOVER_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic enter_command_request,
   input wire logic enter_raw_request,
   input wire logic enter_normal_request,
   input wire logic conv_active,
   input wire logic meas_done,
   input wire logic bp_below_low,
   input wire logic bp_above_high,
   input wire logic bn_below_low,
   input wire logic bn_above_high,
   input wire logic temp_valid,
   input wire logic [sdmc_pkg::TEMP_W-1:0] temp_value,
   input wire logic supply_lost,
   input wire logic ground_lost,
   output logic mode_command,
   output logic mode_normal,
   output logic mode_raw,
   output logic diag_low,
   output logic diag_high,
   output logic dac_override,
   output logic [11:0] dac_code,
   output logic parity_invert,
   output logic tx_enable,
   output logic pump_enable,
   output logic bridge_discharge_en,
   output logic bp_pull_gnd,
   output logic meas_allow
);
   import sdmc_pkg::*;

   logic [15:0] nvm [NVM_WORDS];
   logic [NVM_BITS-1:0] nvm_flat;
   logic [7:0] tick_cnt;
   logic tick;
   sdmc_mode_e mode;
   sdmc_short_e sc_state;
   logic [11:0] win_cnt;
   logic [31:0] sc_cnt;
   logic [7:0] sig_lfsr;
   logic [7:0] sig_stored;
   logic [3:0] sig_idx;
   logic sig_busy;
   logic sig_por;
   logic sig_fault;
   logic br_pend;
   logic [11:0] br_cnt;
   logic br_fault;
   logic short_fault;
   logic tl_pend;
   logic [31:0] tl_cnt;
   logic tl_fault;
   logic th_fault;
   logic locked;
   logic cfg_digital;
   logic cfg_sig_en;
   logic cfg_conn_en;
   logic cfg_short_en;
   logic cfg_ext_temp;
   logic range_bad;
   logic temp_chk;
   logic any_low;
   logic any_high;
   logic pwr_low;
   logic pwr_high;
   logic dp_write;
   logic [7:0] dp_addr;
   logic [7:0] a_addr;
   logic a_take;
   logic [31:0] next_rdata;
   logic nvm_wr_ok;

   function automatic logic [7:0] sig_step(input logic [7:0] s, input logic [7:0] d);
      logic [7:0] r;
      r = s;
      for (int i = 7; i >= 0; i--) begin
         if (r[7] ^ d[i]) begin
            r = {r[6:0], 1'b0} ^ SIG_POLY;
         end else begin
            r = {r[6:0], 1'b0};
         end
      end
      return r;
   endfunction

   always_comb begin
      for (int w = 0; w < NVM_WORDS; w++) begin
         nvm_flat[16*w +: 16] = nvm[w];
      end
   end

   assign cfg_digital = nvm_flat[CFG_DIGITAL];
   assign cfg_sig_en = nvm_flat[CFG_SIG_EN];
   assign cfg_conn_en = nvm_flat[CFG_CONN_EN];
   assign cfg_short_en = nvm_flat[CFG_SHORT_EN];
   assign cfg_ext_temp = nvm_flat[CFG_EXT_TEMP];
   assign locked = (nvm_flat[LOCK_HI:LOCK_LO] == LOCK_CODE_A) ||
      (nvm_flat[LOCK_HI:LOCK_LO] == LOCK_CODE_B);

   // sequencing tick from the master clock
   assign tick = (tick_cnt == TICK_LAST);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt <= 8'h00;
      end else if (tick) begin
         tick_cnt <= 8'h00;
      end else begin
         tick_cnt <= tick_cnt + 8'h01;
      end
   end

   // operating mode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode <= SDMC_WINDOW;
         win_cnt <= 12'h000;
      end else begin
         case (mode)
            SDMC_WINDOW: begin
               if (enter_command_request) begin
                  mode <= SDMC_COMMAND;
               end else if (tick && win_cnt == CMD_WINDOW_TICKS - 12'h001) begin
                  mode <= SDMC_NORMAL;
               end else if (tick) begin
                  win_cnt <= win_cnt + 12'h001;
               end
            end
            SDMC_COMMAND: begin
               if (enter_raw_request) begin
                  mode <= SDMC_RAW;
               end else if (enter_normal_request) begin
                  mode <= SDMC_NORMAL;
               end
            end
            SDMC_NORMAL: mode <= SDMC_NORMAL;
            SDMC_RAW: mode <= SDMC_RAW;
            default: mode <= SDMC_WINDOW;
         endcase
      end
   end

   // signature engine: one byte of stored configuration per cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sig_busy <= 1'b1;
         sig_por <= 1'b1;
         sig_idx <= 4'h0;
         sig_lfsr <= SIG_SEED;
         sig_stored <= 8'h00;
         sig_fault <= 1'b0;
      end else if (nvm_wr_ok) begin
         sig_busy <= 1'b1;
         sig_por <= 1'b0;
         sig_idx <= 4'h0;
         sig_lfsr <= SIG_SEED;
      end else if (sig_busy) begin
         sig_lfsr <= sig_step(sig_lfsr, nvm_flat[8*sig_idx +: 8]);
         sig_idx <= sig_idx + 4'h1;
         if (sig_idx == SIG_LAST_BYTE) begin
            sig_busy <= 1'b0;
            if (sig_por) begin
               sig_fault <= (sig_step(sig_lfsr, nvm_flat[8*sig_idx +: 8]) != sig_stored);
            end else begin
               sig_stored <= sig_step(sig_lfsr, nvm_flat[8*sig_idx +: 8]);
            end
         end
      end
   end

   // bridge range comparators, latched and flagged after the detection delay
   assign range_bad = conv_active && (bp_below_low || bp_above_high ||
      bn_below_low || bn_above_high);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         br_pend <= 1'b0;
         br_cnt <= 12'h000;
         br_fault <= 1'b0;
      end else if (!br_pend) begin
         br_pend <= range_bad;
         br_cnt <= 12'h000;
      end else if (tick && br_cnt == BRIDGE_DLY_TICKS - 12'h001) begin
         br_fault <= 1'b1;
      end else if (tick && !br_fault) begin
         br_cnt <= br_cnt + 12'h001;
      end
   end

   // short check after each bridge measurement, then recovery
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sc_state <= SDMC_SC_IDLE;
         sc_cnt <= 32'h0000_0000;
         short_fault <= 1'b0;
      end else begin
         case (sc_state)
            SDMC_SC_IDLE: begin
               sc_cnt <= 32'h0000_0000;
               if (meas_done && cfg_short_en) begin
                  sc_state <= SDMC_SC_PULL;
               end
            end
            SDMC_SC_PULL: begin
               if (sc_cnt == 32'(SHORT_PULSE_CYC) - 32'h0000_0001) begin
                  if (bn_below_low) begin
                     short_fault <= 1'b1;
                  end
                  sc_cnt <= 32'h0000_0000;
                  sc_state <= SDMC_SC_RECOVER;
               end else begin
                  sc_cnt <= sc_cnt + 32'h0000_0001;
               end
            end
            SDMC_SC_RECOVER: begin
               if (sc_cnt == 32'(RECOVER) - 32'h0000_0001) begin
                  sc_state <= SDMC_SC_IDLE;
               end else begin
                  sc_cnt <= sc_cnt + 32'h0000_0001;
               end
            end
            default: sc_state <= SDMC_SC_IDLE;
         endcase
      end
   end

   // external temperature range check
   assign temp_chk = cfg_ext_temp && cfg_conn_en && temp_valid;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tl_pend <= 1'b0;
         tl_cnt <= 32'h0000_0000;
         tl_fault <= 1'b0;
         th_fault <= 1'b0;
      end else begin
         if (temp_chk && (temp_value < TEMP_LOW_LIM || temp_value > TEMP_HIGH_LIM)) begin
            tl_pend <= 1'b1;
         end
         if (tl_pend && tick) begin
            if (tl_cnt == 32'(TEMP_DLY) - 32'h0000_0001) begin
               tl_fault <= 1'b1;
            end else if (!tl_fault) begin
               tl_cnt <= tl_cnt + 32'h0000_0001;
            end
         end
         if (temp_chk && cfg_conn_en && range_bad) begin
            th_fault <= 1'b1;
         end
      end
   end

   assign pwr_low = !cfg_digital && supply_lost;
   assign pwr_high = !cfg_digital && ground_lost;
   assign any_high = (cfg_conn_en && br_fault) || (cfg_short_en && short_fault) ||
      th_fault || pwr_high;
   assign any_low = (cfg_sig_en && sig_fault) || (cfg_conn_en && cfg_ext_temp && tl_fault) ||
      pwr_low;

   // diagnostic output steering, upper level wins when both are present
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         diag_low <= 1'b0;
         diag_high <= 1'b0;
         dac_override <= 1'b0;
         dac_code <= DIAG_LOW_CODE;
         parity_invert <= 1'b0;
         tx_enable <= 1'b0;
      end else begin
         diag_high <= any_high;
         diag_low <= any_low && !any_high;
         dac_override <= !cfg_digital && (any_low || any_high);
         dac_code <= any_high ? DIAG_HIGH_CODE : DIAG_LOW_CODE;
         parity_invert <= cfg_digital && (any_low || any_high);
         tx_enable <= !(cfg_digital && (supply_lost || ground_lost));
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_command <= 1'b0;
         mode_normal <= 1'b0;
         mode_raw <= 1'b0;
         pump_enable <= 1'b0;
         bridge_discharge_en <= 1'b0;
         bp_pull_gnd <= 1'b0;
         meas_allow <= 1'b0;
      end else begin
         mode_command <= (mode == SDMC_COMMAND) || (mode == SDMC_WINDOW);
         mode_normal <= (mode == SDMC_NORMAL);
         mode_raw <= (mode == SDMC_RAW);
         pump_enable <= !locked && nvm_wr_ok;
         bridge_discharge_en <= cfg_conn_en && conv_active;
         bp_pull_gnd <= (sc_state == SDMC_SC_PULL);
         meas_allow <= (sc_state == SDMC_SC_IDLE) && !sig_busy;
      end
   end

   // AHB-Lite slave, zero wait states, always OKAY
   assign a_take = hsel && hready && htrans == HTRANS_NONSEQ;
   assign a_addr = haddr[7:0];
   assign nvm_wr_ok = dp_write && !locked && dp_addr <= ADDR_NVM7 && dp_addr[1:0] == 2'b00;

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (a_addr <= ADDR_NVM7 && a_addr[1:0] == 2'b00) begin
         next_rdata = {16'h0000, nvm[a_addr[4:2]]};
      end else if (a_addr == ADDR_SIG) begin
         next_rdata = {24'h00_0000, sig_stored};
      end else if (a_addr == ADDR_STATUS) begin
         next_rdata = {16'h0000, sig_busy, locked, tl_fault, th_fault, short_fault,
            br_fault, sig_fault, diag_high, diag_low, 3'h0, mode};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (hready) begin
            dp_write <= a_take && hwrite && hsize == 3'b010 && haddr[31:8] == 24'h00_0000;
            dp_addr <= a_addr;
            if (a_take && !hwrite) begin
               hrdata <= (haddr[31:8] == 24'h00_0000) ? next_rdata : 32'h0000_0000;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int w = 0; w < NVM_WORDS; w++) begin
            nvm[w] <= 16'h0000;
         end
      end else if (nvm_wr_ok) begin
         nvm[dp_addr[4:2]] <= hwdata[15:0];
      end
   end
endmodule // sdmc_core
`default_nettype wire

// *** sdmc_core_bench.sv ***
// self-checking bench for the diagnostic and mode block
`timescale 1ns/1ps
`default_nettype none
module sdmc_core_bench;
   import sdmc_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0, conv_active = 1'b0, meas_done = 1'b0;
   logic bn_below_low = 1'b0, temp_valid = 1'b0, supply_lost = 1'b0;
   logic bp_below_low = 1'b0, bp_above_high = 1'b0, bn_above_high = 1'b0, ground_lost = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [13:0] temp_value = 14'h0100;
   logic hready, hreadyout, hresp, mode_command, mode_normal, mode_raw, diag_low, diag_high;
   logic dac_override, parity_invert, tx_enable, pump_enable, bridge_discharge_en, bp_pull_gnd, meas_allow;
   logic enter_command_request, enter_raw_request, enter_normal_request;
   logic [11:0] dac_code;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;
   int pump_n = 0;
   int n0;
   assign hready = hreadyout;
   always #5 hclk = ~hclk;
   sdmc_cal_master u_sdmc_cal_master (.hclk(hclk), .enter_command_request(enter_command_request),
      .enter_raw_request(enter_raw_request), .enter_normal_request(enter_normal_request));
   sdmc_core #(.TEMP_DLY(4), .RECOVER(20)) u_sdmc_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .enter_command_request(enter_command_request),
      .enter_raw_request(enter_raw_request), .enter_normal_request(enter_normal_request),
      .conv_active(conv_active), .meas_done(meas_done), .bp_below_low(bp_below_low),
      .bp_above_high(bp_above_high), .bn_below_low(bn_below_low), .bn_above_high(bn_above_high),
      .temp_valid(temp_valid), .temp_value(temp_value), .supply_lost(supply_lost),
      .ground_lost(ground_lost), .mode_command(mode_command), .mode_normal(mode_normal),
      .mode_raw(mode_raw), .diag_low(diag_low), .diag_high(diag_high), .dac_override(dac_override),
      .dac_code(dac_code), .parity_invert(parity_invert), .tx_enable(tx_enable), .pump_enable(pump_enable),
      .bridge_discharge_en(bridge_discharge_en), .bp_pull_gnd(bp_pull_gnd), .meas_allow(meas_allow));
   task automatic complete_run();
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc++;
      if (pump_enable === 1'b1) begin
         pump_n++;
      end
      if (cyc == 20000) begin
         error_cnt++;
         complete_run();
      end
   end
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk32({31'h0, got}, {31'h0, exp});
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask
   // one single word transfer; read data taken at the data phase edge
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] unused;
      ahb(1'b1, a, d, unused);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] got;
      ahb(1'b0, a, 32'h0, got);
      chk32(got, exp);
   endtask
   task automatic rst();
      @(posedge hclk);
      hresetn <= 1'b0;
      bn_below_low <= 1'b0;
      supply_lost <= 1'b0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      wt(20);
   endtask
   task automatic pulse(input logic temp);
      @(posedge hclk);
      temp_valid <= temp;
      meas_done <= !temp;
      @(posedge hclk);
      temp_valid <= 1'b0;
      meas_done <= 1'b0;
   endtask
   function automatic logic [7:0] sig_of(input logic [127:0] v);
      logic [7:0] s;
      s = SIG_SEED;
      for (int i = 0; i < 16; i++) begin
         s = s ^ v[8*i +: 8];
         for (int b = 0; b < 8; b++) begin
            s = s[7] ? {s[6:0], 1'b0} ^ SIG_POLY : {s[6:0], 1'b0};
         end
      end
      return s;
   endfunction
   initial begin
      rst();
      rdc(ADDR_STATUS, 32'h201);
      rdc(8'h30, 32'h0);
      u_sdmc_cal_master.send(1);
      wt(3);
      chk1(mode_raw, 1'b0);
      u_sdmc_cal_master.send(0);
      wt(3);
      chk1(mode_command, 1'b1);
      rdc(ADDR_STATUS, 32'h202);
      u_sdmc_cal_master.send(1);
      u_sdmc_cal_master.send(2);
      u_sdmc_cal_master.send(0);
      wt(3);
      rdc(ADDR_STATUS, 32'h208);
      // digital output, connection and short checks on
      rst();
      u_sdmc_cal_master.send(0);
      u_sdmc_cal_master.send(2);
      wt(3);
      chk1(mode_normal, 1'b1);
      chk1(mode_command, 1'b0);
      wr(8'h18, 32'h000D);
      wt(40);
      rdc(ADDR_SIG, {24'h0, sig_of(128'hD << 96)});
      chk32(32'(pump_n), 32'h1);
      pulse(1'b1);
      wt(1000);
      chk1(diag_low, 1'b0);
      @(posedge hclk);
      conv_active <= 1'b1;
      bp_below_low <= 1'b1;
      wt(3);
      chk1(bridge_discharge_en, 1'b1);
      pulse(1'b1);
      conv_active <= 1'b0;
      bp_below_low <= 1'b0;
      pulse(1'b0);
      wt(100);
      chk1(bp_pull_gnd, 1'b1);
      chk1(meas_allow, 1'b0);
      wt(400);
      chk1(diag_high, 1'b0);
      chk1(meas_allow, 1'b1);
      @(posedge hclk);
      bn_below_low <= 1'b1;
      pulse(1'b0);
      wt(500);
      chk1(diag_high, 1'b1);
      chk1(parity_invert, 1'b1);
      chk1(dac_override, 1'b0);
      rdc(ADDR_STATUS, 32'h0B04);
      @(posedge hclk);
      supply_lost <= 1'b1;
      wt(3);
      chk1(tx_enable, 1'b0);
      // analog output, external temperature with connection check, then lock
      rst();
      u_sdmc_cal_master.send(0);
      u_sdmc_cal_master.send(2);
      wr(8'h18, 32'h0014);
      wt(40);
      @(posedge hclk);
      hsize <= 3'h1;
      wr(8'h04, 32'h5555);
      @(posedge hclk);
      hsize <= 3'h2;
      temp_value <= 14'h2000;
      pulse(1'b1);
      wt(1000);
      chk1(diag_low, 1'b0);
      rdc(8'h04, 32'h0);
      @(posedge hclk);
      temp_value <= 14'h3F81;
      pulse(1'b1);
      wt(1000);
      chk1(diag_low, 1'b1);
      chk1(dac_override, 1'b1);
      chk32({20'h0, dac_code}, 32'h0);
      @(posedge hclk);
      supply_lost <= 1'b1;
      wt(3);
      chk1(tx_enable, 1'b1);
      @(posedge hclk);
      supply_lost <= 1'b0;
      ground_lost <= 1'b1;
      wt(3);
      chk1(diag_high, 1'b1);
      chk32({20'h0, dac_code}, 32'hFFF);
      @(posedge hclk);
      ground_lost <= 1'b0;
      wt(3);
      wr(8'h18, 32'h0194);
      wt(40);
      n0 = pump_n;
      wr(8'h00, 32'h1234);
      wt(5);
      chk32(32'(pump_n), 32'(n0));
      rdc(8'h00, 32'h0);
      rdc(8'h18, 32'h0194);
      rdc(ADDR_STATUS, 32'h6284);
      chk1(hresp, 1'b0);
      @(posedge hclk);
      conv_active <= 1'b1;
      bn_above_high <= 1'b1;
      pulse(1'b1);
      wt(3);
      chk1(diag_high, 1'b1);
      chk32({20'h0, dac_code}, 32'hFFF);
      complete_run();
   end
endmodule // sdmc_core_bench
`default_nettype wire

// *** sdmc_core_monitor.sv ***
// assertions on the ports of the diagnostic and mode block
`timescale 1ns/1ps
`default_nettype none
module sdmc_core_monitor (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic conv_active,
   input wire logic supply_lost,
   input wire logic ground_lost,
   input wire logic mode_raw,
   input wire logic diag_low,
   input wire logic diag_high,
   input wire logic dac_override,
   input wire logic [11:0] dac_code,
   input wire logic parity_invert,
   input wire logic tx_enable,
   input wire logic pump_enable,
   input wire logic bridge_discharge_en,
   input wire logic bp_pull_gnd,
   input wire logic meas_allow
);
   import sdmc_pkg::*;
   logic [9:0] pull_cnt;
   logic wr_req;
   assign wr_req = hsel && htrans == HTRANS_NONSEQ && hwrite;
   // length of the current pull-to-ground pulse
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pull_cnt <= 10'h000;
      end else begin
         pull_cnt <= bp_pull_gnd ? pull_cnt + 10'h001 : 10'h000;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_low_level: assert property (dac_override && diag_low |-> dac_code == DIAG_LOW_CODE)
      else $error("low fault code wrong");
   chk_high_level: assert property (dac_override && diag_high |-> dac_code == DIAG_HIGH_CODE)
      else $error("high fault code wrong");
   chk_parity_cause: assert property (parity_invert |-> diag_low || diag_high)
      else $error("parity inverted without fault");
   chk_pump_cause: assert property (pump_enable |-> $past(wr_req, 2) || $past(wr_req, 3))
      else $error("pump pulse without write");
   chk_discharge_cause: assert property (bridge_discharge_en |-> $past(conv_active))
      else $error("discharge outside conversion");
   chk_pulse_length: assert property ($fell(bp_pull_gnd) |-> pull_cnt == 10'(SHORT_PULSE_CYC))
      else $error("short pulse length wrong");
   chk_pulse_hold: assert property (bp_pull_gnd |-> !meas_allow)
      else $error("measurement allowed during pulse");
   chk_recover_hold: assert property ($fell(bp_pull_gnd) |-> !meas_allow [*8])
      else $error("recovery too short");
   chk_tx_stop: assert property ($fell(tx_enable) |-> $past(supply_lost || ground_lost))
      else $error("transmit stopped without power loss");
   chk_raw_stays: assert property (mode_raw |=> mode_raw)
      else $error("raw mode left");
endmodule // sdmc_core_monitor
bind sdmc_core sdmc_core_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .conv_active(conv_active), .supply_lost(supply_lost), .ground_lost(ground_lost),
   .mode_raw(mode_raw), .diag_low(diag_low), .diag_high(diag_high), .dac_override(dac_override),
   .dac_code(dac_code), .parity_invert(parity_invert), .tx_enable(tx_enable), .pump_enable(pump_enable),
   .bridge_discharge_en(bridge_discharge_en), .bp_pull_gnd(bp_pull_gnd), .meas_allow(meas_allow));
`default_nettype wire

// *** sdmc_pkg.sv ***
// constants, field positions and types for the sensor diagnostic and mode block
package sdmc_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned OSC_HZ = 512_000;
   localparam int unsigned TICK_DIV = CLK_HZ / OSC_HZ;
   localparam logic [7:0] TICK_LAST = 8'(TICK_DIV - 1);

   localparam int unsigned CMD_WINDOW_MS = 3;
   localparam logic [11:0] CMD_WINDOW_TICKS = 12'(OSC_HZ * CMD_WINDOW_MS / 1000);
   localparam int unsigned BRIDGE_DLY_MS = 2;
   localparam logic [11:0] BRIDGE_DLY_TICKS = 12'(OSC_HZ * BRIDGE_DLY_MS / 1000);
   localparam int unsigned TEMP_DLY_MS = 300;
   localparam int unsigned TEMP_DLY_TICKS = OSC_HZ * TEMP_DLY_MS / 1000;
   localparam int unsigned SHORT_PULSE_NS = 4000;
   localparam logic [8:0] SHORT_PULSE_CYC = 9'(SHORT_PULSE_NS / (1_000_000_000 / CLK_HZ));
   localparam int unsigned RECOVER_US = 480;
   localparam int unsigned RECOVER_CYC = RECOVER_US * (CLK_HZ / 1_000_000);

   localparam int unsigned TEMP_W = 14;
   localparam logic [13:0] TEMP_LOW_LIM = 14'((1 << TEMP_W) / 32);
   localparam logic [13:0] TEMP_HIGH_LIM = 14'((1 << TEMP_W) / 64 * 63);

   localparam logic [11:0] DIAG_LOW_CODE = 12'h000;
   localparam logic [11:0] DIAG_HIGH_CODE = 12'hFFF;

   localparam int unsigned NVM_WORDS = 8;
   localparam int unsigned NVM_BITS = 16 * NVM_WORDS;
   localparam int unsigned LOCK_HI = 105;
   localparam int unsigned LOCK_LO = 103;
   localparam logic [2:0] LOCK_CODE_A = 3'b011;
   localparam logic [2:0] LOCK_CODE_B = 3'b110;
   localparam int unsigned CFG_DIGITAL = 96;
   localparam int unsigned CFG_SIG_EN = 97;
   localparam int unsigned CFG_CONN_EN = 98;
   localparam int unsigned CFG_SHORT_EN = 99;
   localparam int unsigned CFG_EXT_TEMP = 100;

   localparam logic [7:0] SIG_SEED = 8'hFF;
   localparam logic [7:0] SIG_POLY = 8'h1D;
   localparam logic [3:0] SIG_LAST_BYTE = 4'hF;

   localparam logic [7:0] ADDR_NVM0 = 8'h00;
   localparam logic [7:0] ADDR_NVM7 = 8'h1C;
   localparam logic [7:0] ADDR_SIG = 8'h20;
   localparam logic [7:0] ADDR_STATUS = 8'h24;

   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

   typedef enum logic [3:0] {
      SDMC_WINDOW = 4'b0001,
      SDMC_COMMAND = 4'b0010,
      SDMC_NORMAL = 4'b0100,
      SDMC_RAW = 4'b1000
   } sdmc_mode_e;

   typedef enum logic [2:0] {
      SDMC_SC_IDLE = 3'b001,
      SDMC_SC_PULL = 3'b010,
      SDMC_SC_RECOVER = 3'b100
   } sdmc_short_e;
endpackage
